//--- readout_ctrl_end.sv
// readout controller end and its sample fifo
// Overview of operation
// - sensor shifts on first edge after fall
// - integration is high time plus 48
// - first valid sample at trigger 89
// - start high at least 6 periods
// - start low at least 92 periods
// - pixel clock 200 kHz to 10 MHz; a full buffer stops it and the bench runs it at 15.625 MHz
// - select high reads channels 513 to 1536
// - select low reads all 2048 channels
// - sample video on trigger rising edge
// - shutter set by high/low split
// - full scan repeats every 2140 periods or more
// - central scan repeats every 1116 periods or more
// - all pixels integrate together
// assumes the sensor end sits on the link interface
`timescale 1ns/1ps
module stream_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             resetn,
   // fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q, wrPtr_d;
   logic [AW:0] rdPtr_q, rdPtr_d;
   logic push, pop;

   // pointer arithmetic with wrap bit
   always_comb begin
      inReady  = (wrPtr_q[AW-1:0] != rdPtr_q[AW-1:0]) || (wrPtr_q[AW] == rdPtr_q[AW]);
      outValid = (wrPtr_q != rdPtr_q);
      push     = inValid && inReady;
      pop      = outValid && outReady;
      wrPtr_d  = push ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d  = pop ? rdPtr_q + 1'b1 : rdPtr_q;
   end

   // pointer registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
      end
   end

   // storage, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   assign outData = mem[rdPtr_q[AW-1:0]];
endmodule // stream_fifo

module readout_ctrl_end #(
   parameter int unsigned PIX_PERIOD = scan_timing_pkg::PIX_PERIOD_CYC,
   parameter int unsigned DEPTH      = scan_timing_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                           mclk,
   input  wire logic                           resetn,
   // link
   scan_link_if.controller                     link,
   // scan control
   input  wire logic                           runEnable,
   input  wire logic                           centralOnly,
   input  wire logic [scan_timing_pkg::CNT_W-1:0] highClocks,
   // pixel stream
   output logic                                outValid,
   input  wire logic                           outReady,
   output logic [scan_timing_pkg::VIDEO_W-1:0] outData,
   output logic                                outFirst
);
   import scan_timing_pkg::*;

   localparam logic [PIX_CNT_W-1:0] PER_LAST = PIX_CNT_W'(PIX_PERIOD - 1);
   localparam logic [PIX_CNT_W-1:0] PER_HALF = PIX_CNT_W'(PIX_PERIOD / 2);

   logic [PIX_CNT_W-1:0] divCnt_q, divCnt_d;
   logic pixClk_q, pixClk_d;
   ctrl_state_t state_q, state_d;
   logic [CNT_W-1:0] phaseCnt_q, phaseCnt_d;
   logic [CNT_W-1:0] highTgt_q, highTgt_d;
   logic start_q, start_d;
   logic bsel_q, bsel_d;
   logic [CNT_W-1:0] scanLen_q, scanLen_d;
   logic [CNT_W-1:0] trigCnt_q, trigCnt_d;
   logic [CNT_W-1:0] taken_q, taken_d;
   logic [2:0] trigSync_q;
   logic [VIDEO_W-1:0] sample_q, sample_d;
   logic first_q, first_d;
   logic pend_q, pend_d;
   logic fifoReady, stall, fallEn, trigRise;
   logic [VIDEO_W:0] fifoOut;

   // stall the pixel clock while a sample waits on a full buffer
   assign stall    = pend_q && !fifoReady;
   assign fallEn   = !stall && (divCnt_q == PER_HALF - 1'b1);
   assign trigRise = trigSync_q[1] & ~trigSync_q[2];

   always_comb begin
      divCnt_d = divCnt_q;
      pixClk_d = pixClk_q;
      if (!stall) begin
         divCnt_d = (divCnt_q == PER_LAST) ? '0 : divCnt_q + 1'b1;
         pixClk_d = (divCnt_d < PER_HALF);
      end
   end

   // start pulse sequencer, steps on pixel falls
   always_comb begin
      state_d    = state_q;
      phaseCnt_d = phaseCnt_q;
      highTgt_d  = highTgt_q;
      start_d    = start_q;
      bsel_d     = bsel_q;
      scanLen_d  = scanLen_q;
      case (state_q)
         C_IDLE: begin
            if (fallEn && runEnable) begin
               state_d    = C_HIGH;
               start_d    = 1'b1;
               phaseCnt_d = 16'h0001;
               // select moves only at a new cycle
               bsel_d     = centralOnly;
               highTgt_d  = maxCnt(maxCnt(highClocks, START_HIGH_MIN),
                                   (centralOnly ? CYCLE_CENTRAL : CYCLE_FULL)
                                   - START_LOW_MIN);
            end
         end
         C_HIGH: begin
            if (fallEn) begin
               if (phaseCnt_q == highTgt_q) begin
                  state_d    = C_LOW;
                  start_d    = 1'b0;
                  phaseCnt_d = 16'h0001;
                  scanLen_d  = bsel_q ? PIXELS_CENTRAL : PIXELS_ALL;
               end else begin
                  phaseCnt_d = phaseCnt_q + 16'h0001;
               end
            end
         end
         C_LOW: begin
            if (fallEn) begin
               if (phaseCnt_q == START_LOW_MIN) begin
                  state_d    = runEnable ? C_HIGH : C_IDLE;
                  start_d    = runEnable;
                  phaseCnt_d = 16'h0001;
                  bsel_d     = runEnable ? centralOnly : bsel_q;
                  highTgt_d  = maxCnt(maxCnt(highClocks, START_HIGH_MIN),
                                      (centralOnly ? CYCLE_CENTRAL : CYCLE_FULL)
                                      - START_LOW_MIN);
               end else begin
                  phaseCnt_d = phaseCnt_q + 16'h0001;
               end
            end
         end
         default: begin
            state_d = C_IDLE;
            start_d = 1'b0;
         end
      endcase
   end

   // trigger counting and video capture
   always_comb begin
      trigCnt_d = trigCnt_q;
      taken_d   = taken_q;
      sample_d  = sample_q;
      first_d   = first_q;
      pend_d    = pend_q && !fifoReady;
      if (state_q == C_HIGH && state_d == C_LOW) begin
         trigCnt_d = '0;
         taken_d   = '0;
      end else if (trigRise) begin
         trigCnt_d = trigCnt_q + 16'h0001;
         // from trigger 89 up to scan length
         if (trigCnt_d >= FIRST_VALID_TRIG && taken_q < scanLen_q) begin
            sample_d = link.video;
            first_d  = (taken_q == '0);
            pend_d   = 1'b1;
            taken_d  = taken_q + 16'h0001;
         end
      end
   end

   // registers of divider, sequencer and capture
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         divCnt_q   <= '0;
         pixClk_q   <= 1'b0;
         state_q    <= C_IDLE;
         phaseCnt_q <= '0;
         highTgt_q  <= START_HIGH_MIN;
         start_q    <= 1'b0;
         bsel_q     <= 1'b0;
         scanLen_q  <= PIXELS_ALL;
         trigCnt_q  <= '0;
         taken_q    <= PIXELS_ALL;
         trigSync_q <= 3'h0;
         sample_q   <= '0;
         first_q    <= 1'b0;
         pend_q     <= 1'b0;
      end else begin
         divCnt_q   <= divCnt_d;
         pixClk_q   <= pixClk_d;
         state_q    <= state_d;
         phaseCnt_q <= phaseCnt_d;
         highTgt_q  <= highTgt_d;
         start_q    <= start_d;
         bsel_q     <= bsel_d;
         scanLen_q  <= scanLen_d;
         trigCnt_q  <= trigCnt_d;
         taken_q    <= taken_d;
         trigSync_q <= {trigSync_q[1:0], link.trig};
         sample_q   <= sample_d;
         first_q    <= first_d;
         pend_q     <= pend_d;
      end
   end

   // sample buffer toward the user
   stream_fifo #(
      .WIDTH (VIDEO_W + 1),
      .DEPTH (DEPTH)
   ) sampleFifo (
      .mclk     (mclk),
      .resetn   (resetn),
      .inValid  (pend_q),
      .inReady  (fifoReady),
      .inData   ({first_q, sample_q}),
      .outValid (outValid),
      .outReady (outReady),
      .outData  (fifoOut)
   );

   assign outData               = fifoOut[VIDEO_W-1:0];
   assign outFirst              = fifoOut[VIDEO_W];
   assign link.pixClk           = pixClk_q;
   assign link.scanStartPulse   = start_q;
   assign link.blockSelectInput = bsel_q;
endmodule // readout_ctrl_end

//--- scan_timing_pkg.sv
// shared constants and types for the linear sensor scan link
// assumes both ends run on one 125 MHz system clock
package scan_timing_pkg;
   localparam int unsigned CLOCK_HZ = 125_000_000;
   localparam int unsigned PIX_HZ_MAX = 10_000_000;
   localparam int unsigned PIX_HZ_MIN = 200_000;
   // least pixel period rounds up, longest rounds down
   localparam int unsigned PIX_PERIOD_CYC = (CLOCK_HZ + PIX_HZ_MAX - 1) / PIX_HZ_MAX;
   localparam int unsigned PIX_PERIOD_MAX_CYC = CLOCK_HZ / PIX_HZ_MIN;
   localparam int unsigned PIX_CNT_W = 10;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned VIDEO_W = 12;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [CNT_W-1:0] PIXELS_ALL = 16'h0800;
   localparam logic [CNT_W-1:0] PIXELS_CENTRAL = 16'h0400;
   localparam logic [CNT_W-1:0] FIRST_CH_ALL = 16'h0001;
   localparam logic [CNT_W-1:0] FIRST_CH_CENTRAL = 16'h0201;
   localparam logic [CNT_W-1:0] LAST_CH_CENTRAL = 16'h0600;
   localparam logic [CNT_W-1:0] FIRST_VALID_TRIG = 16'h0059;
   localparam logic [CNT_W-1:0] INTEG_EXTRA = 16'h0030;
   localparam logic [CNT_W-1:0] START_HIGH_MIN = 16'h0006;
   localparam logic [CNT_W-1:0] START_LOW_MIN = 16'h005C;
   localparam logic [CNT_W-1:0] CYCLE_FULL = 16'h085C;
   localparam logic [CNT_W-1:0] CYCLE_CENTRAL = 16'h045C;
   // device scan sequencer
   typedef enum logic [1:0] {
      D_IDLE  = 2'b00,
      D_ARMED = 2'b01,
      D_SCAN  = 2'b11
   } dev_state_t;
   // controller start pulse sequencer
   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_HIGH = 2'b01,
      C_LOW  = 2'b11
   } ctrl_state_t;
   // larger of two counts
   function automatic logic [CNT_W-1:0] maxCnt(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
      return (a > b) ? a : b;
   endfunction
endpackage

//--- scan_link_if.sv
// wires between the sensor end and the readout controller end
// assumes the testbench instantiates it and joins both ends
`timescale 1ns/1ps
interface scan_link_if;
   import scan_timing_pkg::*;
   logic               pixClk;
   logic               scanStartPulse;
   logic               blockSelectInput;
   logic               trig;
   logic [VIDEO_W-1:0] video;
   modport sensor (
      input  pixClk,
      input  scanStartPulse,
      input  blockSelectInput,
      output trig,
      output video
   );
   modport controller (
      output pixClk,
      output scanStartPulse,
      output blockSelectInput,
      input  trig,
      input  video
   );
endinterface

//--- sensor_scan_end.sv
// sensor end: integration and scan timing of the pixel array
// assumes link inputs come from another party and are synchronised here
`timescale 1ns/1ps
module sensor_scan_end (
   // clock and reset
   input  wire logic                         mclk,
   input  wire logic                         resetn,
   // link
   scan_link_if.sensor                       link,
   // user side status
   output logic                              scanning,
   output logic [scan_timing_pkg::CNT_W-1:0] integTime
);
   import scan_timing_pkg::*;

   logic [2:0] clkSync_q;
   logic [2:0] startSync_q;
   logic [1:0] bsSync_q;
   dev_state_t state_q, state_d;
   logic [CNT_W-1:0] trigCnt_q, trigCnt_d;
   logic [CNT_W-1:0] intCnt_q, intCnt_d;
   logic [CNT_W-1:0] postCnt_q, postCnt_d;
   logic [CNT_W-1:0] held_q, held_d;
   logic integ_q, integ_d;
   logic central_q, central_d;
   logic trig_q, trig_d;
   logic [VIDEO_W-1:0] video_q, video_d;
   logic pixRise, pixFall, startRise, startFall;
   logic [CNT_W-1:0] lastTrig, firstCh, chan;

   // pin synchronisers, third stage only for edges
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         clkSync_q <= 3'h0;
         startSync_q <= 3'h0;
         bsSync_q  <= 2'h0;
      end else begin
         clkSync_q <= {clkSync_q[1:0], link.pixClk};
         startSync_q <= {startSync_q[1:0], link.scanStartPulse};
         bsSync_q  <= {bsSync_q[0], link.blockSelectInput};
      end
   end

   assign pixRise = clkSync_q[1] & ~clkSync_q[2];
   assign pixFall = ~clkSync_q[1] & clkSync_q[2];
   assign startRise = startSync_q[1] & ~startSync_q[2];
   assign startFall = ~startSync_q[1] & startSync_q[2];
   assign lastTrig = central_q ? FIRST_VALID_TRIG - 16'h0001 + PIXELS_CENTRAL
                               : FIRST_VALID_TRIG - 16'h0001 + PIXELS_ALL;
   assign firstCh  = central_q ? FIRST_CH_CENTRAL : FIRST_CH_ALL;

   // next state of integration and scan
   always_comb begin
      state_d   = state_q;
      trigCnt_d = trigCnt_q;
      intCnt_d  = intCnt_q;
      postCnt_d = postCnt_q;
      held_d    = held_q;
      integ_d   = integ_q;
      central_d = central_q;
      trig_d    = trig_q;
      video_d   = video_q;
      chan      = firstCh + trigCnt_q - FIRST_VALID_TRIG + 16'h0001;
      if (startRise) begin
         integ_d  = 1'b1;
         intCnt_d = '0;
      end else if (pixRise && integ_q) begin
         intCnt_d = intCnt_q + 16'h0001;
         if (!startSync_q[1]) begin
            postCnt_d = postCnt_q + 16'h0001;
         end
         if (!startSync_q[1] && postCnt_d == INTEG_EXTRA) begin
            integ_d = 1'b0;
            held_d  = intCnt_d;
         end
      end
      if (startFall) begin
         postCnt_d = '0;
      end
      if (pixFall) begin
         trig_d = 1'b0;
      end
      case (state_q)
         D_IDLE: begin
            if (startFall) begin
               state_d   = D_ARMED;
               central_d = bsSync_q[1];
            end
         end
         D_ARMED: begin
            if (pixRise) begin
               state_d   = D_SCAN;
               trigCnt_d = 16'h0001;
               trig_d    = 1'b1;
               video_d   = '0;
            end
         end
         D_SCAN: begin
            if (startFall) begin
               state_d   = D_ARMED;
               central_d = bsSync_q[1];
            end else if (pixRise) begin
               if (trigCnt_q == lastTrig) begin
                  state_d = D_IDLE;
               end else begin
                  trigCnt_d = trigCnt_q + 16'h0001;
                  trig_d    = 1'b1;
                  video_d   = '0;
                  // first valid pixel at trigger 89
                  if (trigCnt_d >= FIRST_VALID_TRIG) begin
                     video_d = VIDEO_W'(held_q + chan);
                  end
               end
            end
         end
         default: state_d = D_IDLE;
      endcase
   end

   // registers of integration and scan
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q   <= D_IDLE;
         trigCnt_q <= '0;
         intCnt_q  <= '0;
         postCnt_q <= '0;
         held_q    <= '0;
         integ_q   <= 1'b0;
         central_q <= 1'b0;
         trig_q    <= 1'b0;
         video_q   <= '0;
      end else begin
         state_q   <= state_d;
         trigCnt_q <= trigCnt_d;
         intCnt_q  <= intCnt_d;
         postCnt_q <= postCnt_d;
         held_q    <= held_d;
         integ_q   <= integ_d;
         central_q <= central_d;
         trig_q    <= trig_d;
         video_q   <= video_d;
      end
   end

   assign link.trig  = trig_q;
   assign link.video = video_q;
   assign scanning   = (state_q == D_SCAN);
   assign integTime  = held_q;
endmodule // sensor_scan_end

//--- scan_link_assertions.sv
// link checker: trigger, video, start pulse and block select timing
// assumes one clock, and the link signals are handed in as plain inputs
`timescale 1ns/1ps
module scan_link_assertions (
   // clock and reset
   input wire logic                                mclk,
   input wire logic                                resetn,
   // link
   input wire logic                                pixClk,
   input wire logic                                scanStartPulse,
   input wire logic                                blockSelectInput,
   input wire logic                                trig,
   input wire logic [scan_timing_pkg::VIDEO_W-1:0] video
);
   import scan_timing_pkg::*;
   logic [CNT_W-1:0] trigCnt_q, trigCnt_d, highCnt_q, highCnt_d, lowCnt_q, lowCnt_d;
   logic             bsel_q, bsel_d, startPrev_q, trPrev_q, pxPrev_q, fellOnce_q;
   logic             startFell, trRose, pxRose;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // edge detects, triggers since start fall, clock rises while start high
   always_comb begin
      startFell = startPrev_q & ~scanStartPulse;
      trRose    = trig & ~trPrev_q;
      pxRose    = pixClk & ~pxPrev_q;
      trigCnt_d = startFell ? '0 : trigCnt_q + CNT_W'(trRose);
      highCnt_d = scanStartPulse ? highCnt_q + CNT_W'(pxRose) : '0;
      lowCnt_d  = scanStartPulse ? '0 : lowCnt_q + CNT_W'(pxRose);
      bsel_d    = startFell ? blockSelectInput : bsel_q;
   end

   // helper registers
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         {trigCnt_q, highCnt_q, lowCnt_q} <= '0;
         {bsel_q, startPrev_q, trPrev_q, pxPrev_q, fellOnce_q} <= '0;
      end else begin
         {trigCnt_q, highCnt_q, lowCnt_q, bsel_q} <= {trigCnt_d, highCnt_d, lowCnt_d, bsel_d};
         {startPrev_q, trPrev_q, pxPrev_q} <= {scanStartPulse, trig, pixClk};
         fellOnce_q <= fellOnce_q | startFell; // low time known only after a fall
      end
   end

   a_shift_after_fall: assert property (
      $fell(scanStartPulse) |-> (!trRose)[*4] ##[1:40] trRose)
      else $error("first trigger after start fall missing");
   a_trig_follows_clk: assert property (
      trRose |-> $past(pixClk, 2))
      else $error("trigger rise without pixel clock rise");
   a_video_on_trig: assert property (
      $changed(video) |-> trRose)
      else $error("video changed away from a trigger rise");
   a_lead_in_zero: assert property (
      trRose && trigCnt_q < FIRST_VALID_TRIG - 16'h0001 |-> video == '0)
      else $error("video not zero before first valid trigger");
   a_first_sample: assert property (
      trRose && trigCnt_q == FIRST_VALID_TRIG - 16'h0001 |-> video != '0)
      else $error("no video on first valid trigger");
   a_scan_length: assert property (
      trRose |-> trigCnt_q < FIRST_VALID_TRIG - 16'h0001 + (bsel_q ? PIXELS_CENTRAL : PIXELS_ALL))
      else $error("too many triggers in one scan");
   a_bsel_between: assert property (
      $changed(blockSelectInput) |-> $rose(scanStartPulse))
      else $error("block select changed inside a scan");
   a_start_high_min: assert property (
      startFell |-> highCnt_q >= START_HIGH_MIN)
      else $error("start pulse high too short");
   a_start_low_min: assert property (
      $rose(scanStartPulse) && fellOnce_q |-> lowCnt_q >= START_LOW_MIN)
      else $error("start pulse low too short");
endmodule // scan_link_assertions

//--- linear_sensor_scan_timing_tb.sv
// bench joining the sensor end and the controller end over the link
// assumes package, interface, both ends and the link checker compile first
`timescale 1ns/1ps
module linear_sensor_scan_timing_tb;
   import scan_timing_pkg::*;
   localparam int TIMEOUT = 95000;
   typedef struct packed {
      logic             central;
      logic [CNT_W-1:0] high;
      logic [CNT_W-1:0] pixels;
      logic [CNT_W-1:0] firstCh;
      logic [CNT_W-1:0] integ;
   } row_t;
   // select, start high, pixel count, first channel, integration time
   localparam row_t ROWS [3] = '{
      '{1'b0, 16'h0000, 16'h0800, 16'h0001, 16'h0830},
      '{1'b1, 16'h0000, 16'h0400, 16'h0201, 16'h0430},
      '{1'b1, 16'h044C, 16'h0400, 16'h0201, 16'h047C}};
   logic               mclk        = 1'b0;
   logic               resetn      = 1'b0;
   logic               runEnable   = 1'b0;
   logic               centralOnly = 1'b0;
   logic [CNT_W-1:0]   highClocks  = '0;
   logic               outReady    = 1'b1;
   logic               scanning, outValid, outFirst;
   logic [CNT_W-1:0]   integTime;
   logic [VIDEO_W-1:0] outData;
   logic [CNT_W-1:0]   trigCnt     = '0;
   logic               startLast   = 1'b0;
   logic               trLast      = 1'b0;
   logic               pixLast;
   logic [7:0]         toggles;
   int                 cycles      = 0;
   int                 n_fail      = 0;
   int                 total_checks = 0;

   scan_link_if lnk ();
   sensor_scan_end u_sensor_scan_end (.mclk(mclk), .resetn(resetn), .link(lnk.sensor),
      .scanning(scanning), .integTime(integTime));
   readout_ctrl_end #(.PIX_PERIOD(8), .DEPTH(16)) u_readout_ctrl_end (.mclk(mclk),
      .resetn(resetn), .link(lnk.controller), .runEnable(runEnable),
      .centralOnly(centralOnly), .highClocks(highClocks), .outValid(outValid),
      .outReady(outReady), .outData(outData), .outFirst(outFirst));
   scan_link_assertions u_scan_link_assertions (.mclk(mclk), .resetn(resetn),
      .pixClk(lnk.pixClk), .scanStartPulse(lnk.scanStartPulse),
      .blockSelectInput(lnk.blockSelectInput), .trig(lnk.trig), .video(lnk.video));

   // 125 MHz system clock
   always #4 mclk = ~mclk;

   // trigger rises since the last start fall, and the hang limit
   always @(posedge mclk) begin
      if (startLast === 1'b1 && lnk.scanStartPulse === 1'b0) trigCnt = '0;
      else if (trLast === 1'b0 && lnk.trig === 1'b1) trigCnt++;
      startLast = lnk.scanStartPulse;
      trLast = lnk.trig;
      cycles++;
      if (cycles == TIMEOUT) begin
         n_fail++;
         end_of_test();
      end
   end

   // compare and count
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // summary and verdict
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // reset for two cycles, idle levels checked before release
   task automatic do_reset();
      resetn    <= 1'b0;
      runEnable <= 1'b0;
      repeat (2) @(posedge mclk);
      check("reset", {lnk.pixClk, lnk.scanStartPulse, lnk.blockSelectInput, lnk.trig,
         lnk.video, scanning, outValid}, '0);
      check("integReset", integTime, '0);
      resetn <= 1'b1;
   endtask

   // pop n samples, each integration time plus its channel
   task automatic pop_run(input logic [CNT_W-1:0] n, ch, integ);
      logic [VIDEO_W-1:0] exp;
      for (int i = 0; i < n; i++) begin
         do @(posedge mclk); while (!(outValid === 1'b1 && outReady === 1'b1));
         exp = VIDEO_W'(integ + ch + CNT_W'(i));
         check("pixel", {outFirst, outData}, {i == 0, exp});
      end
   endtask

   // main sequence
   initial begin
      foreach (ROWS[r]) begin
         do_reset();
         centralOnly <= ROWS[r].central;
         highClocks  <= ROWS[r].high;
         runEnable   <= 1'b1;
         pop_run(ROWS[r].pixels, ROWS[r].firstCh, ROWS[r].integ);
         repeat (16) @(posedge mclk);
         check("integTime", integTime, ROWS[r].integ);
         check("triggers", trigCnt, FIRST_VALID_TRIG - 16'h0001 + ROWS[r].pixels);
         check("scanEnd", scanning, 1'b0);
      end
      // full buffer stalls the pixel clock, then drains without loss
      do_reset();
      centralOnly <= 1'b1;
      highClocks  <= '0;
      outReady    <= 1'b0;
      runEnable   <= 1'b1;
      do @(posedge mclk); while (outValid !== 1'b1);
      repeat (400) @(posedge mclk);
      pixLast = lnk.pixClk;
      toggles = '0;
      repeat (64) begin
         @(posedge mclk);
         if (lnk.pixClk !== pixLast) toggles++;
      end
      check("stall", toggles, '0);
      outReady <= 1'b1;
      pop_run(16'h0028, 16'h0201, 16'h0430);
      end_of_test();
   end
endmodule // linear_sensor_scan_timing_tb
